/* core/mprf_routing.v */
// Contract
// RL1: sysex accepted only for own unit number
// RL2: per-port controller send mode off/cc/nrpn
// RL3: incoming cc and nrpn always accepted
// RL4: per-port program change direction gating
// RL5: chaining disables din program change setting
// RL6: chaining disables din input-to-output thru
// RL7: receive channel all or one of sixteen
// RL8: transmit channel fixed or follows receive
// RL9: din thru forwards din input to output
// RL10: din-to-usb thru forwards din input
// RL11: usb-to-din thru forwards usb input
// RL12: dump goes to din or usb only
// RL13: dump type selects export content
// RL14: bank selector picks one of eight
// RL15: source selects single program or pattern
// RL16: trigger starts export with current settings
// RL17: host must arm capture before trigger; there is no arming here, a write of the go bit starts the export unless exportBusy is high
// RL18: channel filter only hits channel voice messages
// RL19: merge outputs at message boundaries
//
// routing, filtering and export control for the din and usb message ports
// assumes messages arrive whole as status plus two data bytes with a strobe,
// and each output hands over one message per ready handshake
`include "mprf_defines.vh"

module mprf_routing (
  input  wire        clock,
  input  wire        nrst,
  input  wire        enable,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // incoming messages, index 0 din, 1 usb
  input  wire [1:0]  inValid,
  input  wire [15:0] inStatus,
  input  wire [15:0] inData1,
  input  wire [15:0] inData2,
  output reg  [1:0]  acceptLocal,
  // local outgoing message request
  input  wire        locValid,
  input  wire        locPort,
  input  wire [7:0]  locStatus,
  input  wire [7:0]  locData1,
  input  wire [7:0]  locData2,
  input  wire        locIsCtrl,
  input  wire        locIsNrpn,
  output wire        locReady,
  // outgoing messages, index 0 din, 1 usb
  output reg  [1:0]  outValid,
  output reg  [15:0] outStatus,
  output reg  [15:0] outData1,
  output reg  [15:0] outData2,
  input  wire [1:0]  outReady,
  // export request to the dump engine
  output reg         exportStart,
  output reg         exportToUsb,
  output reg  [3:0]  exportType,
  output reg  [2:0]  exportBank,
  output reg  [6:0]  exportSource,
  input  wire        exportBusy
);

  // configuration registers
  reg [3:0]  unitNumber;
  reg [31:0] portCfg [0:1];
  reg [3:0]  thruCfg;
  reg        expDest;
  reg [3:0]  expType;
  reg [2:0]  expBank;
  reg [6:0]  expSrc;
  reg [1:0]  dropCount; // cycles that lost a forward, saturating

  // chaining takes over the din port's program change and thru settings
  wire chainOn = thruCfg[`MPRF_CHAIN_BIT];

  // axi write channel: address and data may arrive in separate cycles, each held until both are in
  // bvalid blocks both readies, so a new write never overtakes an unread response
  reg        awHeld;
  reg [7:0]  awAddr;
  reg        wHeld;
  reg [31:0] wData;
  reg [3:0]  wStrb;
  assign s_axi_awready = enable && !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = enable && !wHeld && !s_axi_bvalid;
  wire [7:0]  wrAddr = awHeld ? awAddr : s_axi_awaddr;
  wire [31:0] wrData = wHeld ? wData : s_axi_wdata;
  wire [3:0]  wrStrb = wHeld ? wStrb : s_axi_wstrb;
  wire awNow = awHeld || (s_axi_awvalid && s_axi_awready);
  wire wNow  = wHeld || (s_axi_wvalid && s_axi_wready);
  wire doWrite = enable && awNow && wNow && !s_axi_bvalid;
  // only aligned offsets up to the status word are mapped; writes to status do nothing
  wire wrMapped = (wrAddr <= `MPRF_REG_STATUS) && (wrAddr[1:0] == 2'b00);

  // merged byte mask for the addressed word
  wire [31:0] wrMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};

  // address/data holding and write response
  always @(posedge clock) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (enable) begin
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? 2'b00 : 2'b10;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          awHeld <= 1'b1;
          awAddr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wHeld <= 1'b1;
          wData <= s_axi_wdata;
          wStrb <= s_axi_wstrb;
        end
        // response stands until the master takes it
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [31:0] next_unit   = ({28'h0, unitNumber} & ~wrMask) | (wrData & wrMask);
  wire [31:0] next_din    = (portCfg[0] & ~wrMask) | (wrData & wrMask);
  wire [31:0] next_usb    = (portCfg[1] & ~wrMask) | (wrData & wrMask);
  wire [31:0] next_thru   = ({28'h0, thruCfg} & ~wrMask) | (wrData & wrMask);
  wire [31:0] expWord     = {13'h0000, expSrc, 1'b0, expBank, expType, 3'b000, expDest};
  wire [31:0] next_export = (expWord & ~wrMask) | (wrData & wrMask);
  wire goWrite = doWrite && wrAddr == `MPRF_REG_EXPORT && wrStrb[3] && wrData[`MPRF_EXP_GO_BIT];

  // fields of the merged export word; an out-of-range type keeps the stored one,
  // and a single user pattern source is cut to the pattern range
  wire        wrDest   = next_export[`MPRF_EXP_DEST_BIT];
  wire [3:0]  wrType   = next_export[`MPRF_EXP_TYPE_LSB +: 4];
  wire        wrTypeOk = wrType <= `MPRF_DT_LAST;
  wire [2:0]  wrBank   = next_export[`MPRF_EXP_BANK_LSB +: 3];
  wire [6:0]  wrSrc    = next_export[`MPRF_EXP_SRC_LSB +: 7];
  wire [6:0]  wrSrcCut = (wrType == `MPRF_DT_SINGLE_USER_PATTERN) ? (wrSrc & `MPRF_PAT_MAX) : wrSrc;

  // register writes and export trigger
  always @(posedge clock) begin
    if (!nrst) begin
      unitNumber <= `MPRF_RST_UNIT;
      portCfg[0] <= `MPRF_RST_PORTCFG;
      portCfg[1] <= `MPRF_RST_PORTCFG;
      thruCfg <= `MPRF_RST_THRU;
      expDest <= 1'b0;
      expType <= `MPRF_DT_PROG;
      expBank <= 3'h0;
      expSrc <= 7'h00;
      exportStart <= 1'b0;
      exportToUsb <= 1'b0;
      exportType <= `MPRF_DT_PROG;
      exportBank <= 3'h0;
      exportSource <= 7'h00;
    end else if (enable) begin
      exportStart <= 1'b0;
      if (doWrite && wrMapped) begin
        case (wrAddr)
          `MPRF_REG_UNIT:   unitNumber <= next_unit[3:0]; // RL1
          `MPRF_REG_DINCFG: portCfg[0] <= next_din & 32'h000F_1F1F;
          `MPRF_REG_USBCFG: portCfg[1] <= next_usb & 32'h000F_1F1F;
          `MPRF_REG_THRU:   thruCfg <= next_thru[3:0];
          `MPRF_REG_EXPORT: begin
            expDest <= wrDest; // RL12
            if (wrTypeOk)
              expType <= wrType; // RL13
            expBank <= wrBank; // RL14
            expSrc <= wrSrc; // RL15
          end
          default: ;
        endcase
      end
      // latch the current selections at the trigger
      if (goWrite && !exportBusy) begin
        exportStart <= 1'b1; // RL16
        exportToUsb <= wrDest; // RL12
        exportType <= wrTypeOk ? wrType : expType; // RL13
        exportBank <= wrBank; // RL14
        exportSource <= wrSrcCut; // RL15
      end
    end
  end

  // axi read channel
  // unmapped or misaligned reads answer slverr with a zero word
  assign s_axi_arready = enable && !s_axi_rvalid;
  always @(posedge clock) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (enable) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `MPRF_REG_UNIT:   s_axi_rdata <= {28'h0, unitNumber};
          `MPRF_REG_DINCFG: s_axi_rdata <= portCfg[0];
          `MPRF_REG_USBCFG: s_axi_rdata <= portCfg[1];
          `MPRF_REG_THRU:   s_axi_rdata <= {28'h0, thruCfg};
          `MPRF_REG_EXPORT: s_axi_rdata <= expWord;
          `MPRF_REG_STATUS: s_axi_rdata <= {27'h0, dropCount, exportBusy, outValid};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // receive filtering per port
  // the din filter drops its program change gate while chaining owns that port
  wire [1:0] filtAccept;
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp = gp + 1) begin : g_rx
      mprf_rx_filter u_filter (
        .statusByte (inStatus[gp*8 +: 8]),
        .firstData  (inData1[gp*8 +: 8]),
        .rxAll      (portCfg[gp][`MPRF_RXALL_BIT]),
        .rxChannel  (portCfg[gp][11:8]),
        .pgmDir     (portCfg[gp][3:2]),
        .pgmIgnore  ((gp == 0) && chainOn), // RL5
        .unitNumber (unitNumber),
        .accept     (filtAccept[gp])
      );
    end
  endgenerate

  // accept pulse to the sound engine; cc and nrpn pass regardless of send mode
  always @(posedge clock) begin
    if (!nrst)
      acceptLocal <= 2'b00;
    else if (enable)
      acceptLocal <= inValid & filtAccept; // RL3
  end

  // forwarding demands: din output gets din-thru and usb-to-din, usb gets din-to-usb
  wire fwdDinDin = inValid[0] && thruCfg[`MPRF_THRU_DIN_BIT] && !chainOn; // RL9 RL6
  wire fwdDinUsb = inValid[0] && thruCfg[`MPRF_THRU_D2U_BIT]; // RL10
  wire fwdUsbDin = inValid[1] && thruCfg[`MPRF_THRU_U2D_BIT]; // RL11

  // local message shaping: channel substitution, ctrl mode and program change gating
  wire [31:0] locCfg = portCfg[locPort];
  wire [3:0]  txCh = locCfg[`MPRF_TXFOL_BIT] ? locCfg[11:8] : locCfg[19:16]; // RL8
  wire        locVoice = locStatus[7:4] != 4'hF;
  wire [1:0]  locMode = locCfg[1:0];
  wire        locPgmOk = !(locPort == 1'b0 && chainOn) &&
                         (locCfg[3:2] == `MPRF_PGM_TX || locCfg[3:2] == `MPRF_PGM_RXTX);
  wire        locDrop = (locIsCtrl && (locMode == `MPRF_CTRL_OFF ||
                          (locIsNrpn != (locMode == `MPRF_CTRL_NRPN)))) || // RL2
                        (locStatus[7:4] == 4'hC && !locPgmOk && !(locPort == 1'b0 && chainOn)); // RL4 RL5
  wire [7:0]  locOutStatus = locVoice ? {locStatus[7:4], txCh} : locStatus; // RL8

  // a local message is placed only when its slot is free and no forward claims it
  wire dinFree = !outValid[0] || outReady[0];
  wire usbFree = !outValid[1] || outReady[1];
  wire dinFwd = fwdDinDin || fwdUsbDin;
  // a forward is lost when its slot is busy, or when both forwards aim at the
  // din output in one cycle and the usb one loses; no buffer holds it back
  wire dinClash = fwdDinDin && fwdUsbDin;
  wire fwdLost  = (dinFwd && !dinFree) || dinClash || (fwdDinUsb && !usbFree);
  // muted or gated locals are taken at once and thrown away, so a sender never stalls
  wire locSlotFree = locPort ? (usbFree && !fwdDinUsb) : (dinFree && !dinFwd);
  assign locReady = enable && (locDrop || locSlotFree); // RL19

  // output slots hold whole messages; forwards win, locals wait at boundaries
  always @(posedge clock) begin
    if (!nrst) begin
      outValid <= 2'b00;
      outStatus <= 16'h0000;
      outData1 <= 16'h0000;
      outData2 <= 16'h0000;
      dropCount <= 2'b00;
    end else if (enable) begin
      if (outValid[0] && outReady[0])
        outValid[0] <= 1'b0;
      if (outValid[1] && outReady[1])
        outValid[1] <= 1'b0;
      // din output
      if (fwdDinDin && dinFree) begin
        outValid[0] <= 1'b1; // RL9 RL19
        outStatus[7:0] <= inStatus[7:0];
        outData1[7:0] <= inData1[7:0];
        outData2[7:0] <= inData2[7:0];
      end else if (fwdUsbDin && dinFree) begin
        outValid[0] <= 1'b1; // RL11 RL19
        outStatus[7:0] <= inStatus[15:8];
        outData1[7:0] <= inData1[15:8];
        outData2[7:0] <= inData2[15:8];
      end else if (locValid && locReady && !locDrop && !locPort) begin
        outValid[0] <= 1'b1; // RL19
        outStatus[7:0] <= locOutStatus;
        outData1[7:0] <= locData1;
        outData2[7:0] <= locData2;
      end
      // usb output
      if (fwdDinUsb && usbFree) begin
        outValid[1] <= 1'b1; // RL10 RL19
        outStatus[15:8] <= inStatus[7:0];
        outData1[15:8] <= inData1[7:0];
        outData2[15:8] <= inData2[7:0];
      end else if (locValid && locReady && !locDrop && locPort) begin
        outValid[1] <= 1'b1; // RL19
        outStatus[15:8] <= locOutStatus;
        outData1[15:8] <= locData1;
        outData2[15:8] <= locData2;
      end
      // a cycle that loses any forward counts once, saturating
      if (fwdLost && dropCount != 2'b11)
        dropCount <= dropCount + 2'b01;
    end
  end

endmodule

/* core/mprf_defines.vh */
// shared constants for the midi port routing filter: register offsets,
// field positions, reset values and export type codes
// assumes an axi4-lite register bus with 32-bit aligned words
`ifndef MPRF_DEFINES_VH
`define MPRF_DEFINES_VH

// register byte offsets
`define MPRF_REG_UNIT      8'h00
`define MPRF_REG_DINCFG    8'h04
`define MPRF_REG_USBCFG    8'h08
`define MPRF_REG_THRU      8'h0C
`define MPRF_REG_EXPORT    8'h10
`define MPRF_REG_STATUS    8'h14

// port config fields
`define MPRF_CTRL_LSB      0
`define MPRF_PGM_LSB       2
`define MPRF_RXALL_BIT     4
`define MPRF_FOLLOW_RECEIVE_CHANNEL_LSB      8
`define MPRF_TXFOL_BIT     12
`define MPRF_TXCH_LSB      16

// controller transmit modes
`define MPRF_CTRL_OFF      2'h0
`define MPRF_CTRL_CC       2'h1
`define MPRF_CTRL_NRPN     2'h2

// program change directions
`define MPRF_PGM_RX        2'h0
`define MPRF_PGM_TX        2'h1
`define MPRF_PGM_RXTX      2'h2
`define MPRF_PGM_NONE      2'h3

// thru fields
`define MPRF_THRU_DIN_BIT  0
`define MPRF_THRU_D2U_BIT  1
`define MPRF_THRU_U2D_BIT  2
`define MPRF_CHAIN_BIT     3

// export fields
`define MPRF_EXP_DEST_BIT  0
`define MPRF_EXP_TYPE_LSB  4
`define MPRF_EXP_BANK_LSB  8
`define MPRF_EXP_SRC_LSB   12
`define MPRF_EXP_GO_BIT    31

// export types
`define MPRF_DT_PROG       4'h0
`define MPRF_DT_BANK       4'h1
`define MPRF_DT_EDIT_BUFFER_PROGRAM   4'h2
`define MPRF_DT_GLOBAL     4'h3
`define MPRF_DT_SINGLE_USER_PATTERN    4'h4
`define MPRF_DT_EDITPAT    4'h5
`define MPRF_DT_ALLPAT     4'h6
`define MPRF_DT_ALL        4'h7
`define MPRF_DT_CAL        4'h8
`define MPRF_DT_CHORD      4'h9
`define MPRF_DT_PCHORD     4'hA
`define MPRF_DT_FAVOR      4'hB
`define MPRF_DT_LAST       4'hB

// reset values and source limits
`define MPRF_RST_UNIT      4'h0
`define MPRF_RST_PORTCFG   32'h0000_0011
`define MPRF_RST_THRU      4'h0
`define MPRF_PROG_MAX      7'h7F
`define MPRF_PAT_MAX       7'h1F

`endif

/* core/mprf_rx_filter.v */
// per-port receive filter: decides if one incoming message is accepted locally
// assumes status byte and first data byte are presented with a start strobe
`include "mprf_defines.vh"

module mprf_rx_filter (
  input  wire [7:0] statusByte,
  input  wire [7:0] firstData,
  input  wire       rxAll,
  input  wire [3:0] rxChannel,
  input  wire [1:0] pgmDir,
  input  wire       pgmIgnore,
  input  wire [3:0] unitNumber,
  output reg        accept
);

  // channel voice check, program change gating, unit addressed sysex
  always @* begin
    accept = 1'b1;
    if (statusByte[7:4] != 4'hF) begin
      if (!rxAll && statusByte[3:0] != rxChannel)
        accept = 1'b0; // RL7 RL18
      if (statusByte[7:4] == 4'hC && !pgmIgnore &&
          (pgmDir == `MPRF_PGM_TX || pgmDir == `MPRF_PGM_NONE))
        accept = 1'b0; // RL4 RL5
    end else if (statusByte == 8'hF0) begin
      if (firstData[3:0] != unitNumber)
        accept = 1'b0; // RL1
    end
  end

endmodule

/* tb/mprf_routing_asserts.sv */
// checker for mprf_routing: ties each output to the input that caused it
// bound to every mprf_routing instance; one clock, synchronous reset
`include "mprf_defines.vh"
module mprf_routing_asserts (
  input logic        clock,
  input logic        nrst,
  input logic        enable,
  input logic        s_axi_arready,
  input logic [1:0]  inValid,
  input logic [1:0]  acceptLocal,
  input logic        locValid,
  input logic        locPort,
  input logic        locReady,
  input logic [1:0]  outValid,
  input logic [15:0] outStatus,
  input logic [1:0]  outReady,
  input logic        exportStart,
  input logic [3:0]  exportType,
  input logic        exportBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dinCause;
  logic usbCause;
  // what may start a message on each output
  assign dinCause = |inValid || (locValid && locReady && !locPort);
  assign usbCause = inValid[0] || (locValid && locReady && locPort);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // verdicts on messages, outputs and exports
  chk_din_accept:
    assert property (acceptLocal[0] |-> $past(inValid[0])) else $error("din accept without message");
  chk_usb_accept:
    assert property (acceptLocal[1] |-> $past(inValid[1])) else $error("usb accept without message");
  chk_out_held:
    assert property (outValid[0] && !outReady[0] |=> outValid[0] && $stable(outStatus[7:0]))
      else $error("din message changed before taken");
  chk_din_cause:
    assert property ($rose(outValid[0]) |-> $past(dinCause)) else $error("din output without cause");
  chk_usb_cause:
    assert property ($rose(outValid[1]) |-> $past(usbCause)) else $error("usb output without cause");
  chk_start_pulse:
    assert property (exportStart |=> !exportStart) else $error("export start longer than a cycle");
  chk_start_busy:
    assert property (exportStart |-> !$past(exportBusy)) else $error("export started while busy");
  chk_type_range:
    assert property (exportStart |-> exportType <= `MPRF_DT_LAST) else $error("export type out of range");
  chk_freeze_ready:
    assert property (!enable |-> !locReady && !s_axi_arready) else $error("ready while disabled");
endmodule

bind mprf_routing mprf_routing_asserts chk_u (.*);

/* tb/mprf_far_side.sv */
// far-side model: an instrument or host taking each outgoing message
// assumes the routing block holds a message until it is taken
module mprf_far_side (
  input  logic            clock,
  input  logic            nrst,
  input  logic            slow,
  input  logic [1:0]      outValid,
  input  logic [15:0]     outStatus,
  output logic [1:0]      outReady,
  output logic [15:0]     lastStatus,
  output logic [1:0][7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phase;
  // ready every cycle, or every other cycle when slow; armed from reset on
  assign outReady = (slow && phase) ? 2'h0 : 2'h3;
  // count each message taken and keep its status byte, per port
  always @(posedge clock) begin
    phase <= ~phase & nrst;
    for (int k = 0; k < 2; k++) begin
      if (!nrst) got[k] <= 8'h00;
      else if (outValid[k] && outReady[k]) begin
        got[k] <= got[k] + 8'h01;
        lastStatus[k*8 +: 8] <= outStatus[k*8 +: 8];
      end
    end
  end
endmodule

/* tb/tb_midi_port_routing_filter.sv */
// bench for mprf_routing: setup over axi4-lite, messages in, outputs compared
// assumes the far-side model takes outputs and the checker is bound
`include "mprf_defines.vh"
module tb_midi_port_routing_filter;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clock = 0, nrst = 0, enable = 1, slow = 0, exportBusy = 0, n;
  logic            s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic            locValid = 0, locPort = 0, locIsCtrl = 0, locIsNrpn = 0;
  logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic            locReady, exportStart, exportToUsb;
  logic [1:0]      inValid = 0, s_axi_bresp, s_axi_rresp, acceptLocal, outValid, outReady, br;
  logic [3:0]      s_axi_wstrb = 4'hF, exportType, c, t, u;
  logic [2:0]      exportBank;
  logic [6:0]      exportSource;
  logic [7:0]      s_axi_awaddr = 0, s_axi_araddr = 0, locStatus = 0, locData1 = 0, locData2 = 0;
  logic [15:0]     inStatus = 0, inData1 = 0, inData2 = 0, outStatus, outData1, outData2, lastStatus;
  logic [1:0][7:0] got;
  logic [31:0]     s_axi_wdata = 0, s_axi_rdata, d;
  logic [31:0]     seed = 32'h0001_129F;
  logic [14:0]     expo;
  int              checks = 0, errCount = 0, cycles = 0, starts = 0, i;

  mprf_routing dut_u (.*);
  mprf_far_side far_u (.*);

  always #4 clock = ~clock;
  // cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errCount++;
      report_and_stop();
    end
  end
  // record each export start with its settings
  always @(posedge clock) if (exportStart) begin
    starts <= starts + 1;
    expo <= {exportToUsb, exportType, exportBank, exportSource};
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected export settings: bad types keep the stored one, user patterns cut to 32
  function automatic logic [14:0] expExport(input logic [31:0] w, input logic [3:0] prev);
    logic [3:0] ty;
    ty = w[7:4] > `MPRF_DT_LAST ? prev : w[7:4];
    return {w[0], ty, w[10:8], w[7:4] == `MPRF_DT_SINGLE_USER_PATTERN ? w[18:12] & `MPRF_PAT_MAX : w[18:12]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // wait until a ready or valid is seen high at a falling edge
  task automatic waitHi(input int s);
    logic k;
    do begin
      @(negedge clock);
      k = s == 0 ? s_axi_bvalid : s == 1 ? s_axi_arready : s == 2 ? s_axi_rvalid : locReady;
      if (s == 2) d = s_axi_rdata;
      br = s == 2 ? s_axi_rresp : s_axi_bresp;
      @(posedge clock);
    end while (!k);
  endtask
  // one register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aD, wD;
    aD = 0;
    wD = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aD && wD)) begin
      @(negedge clock);
      aD = aD | (s_axi_awvalid & s_axi_awready);
      wD = wD | (s_axi_wvalid & s_axi_wready);
      @(posedge clock);
      if (aD) s_axi_awvalid <= 0;
      if (wD) s_axi_wvalid <= 0;
    end
    waitHi(0);
    s_axi_bready <= 0;
    check(br, (a > `MPRF_REG_STATUS || a[1:0] != 2'b00) ? 2'h2 : 2'h0);
    @(posedge clock);
  endtask
  // one register read compared with its expected word and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    waitHi(1);
    s_axi_arvalid <= 0;
    waitHi(2);
    s_axi_rready <= 0;
    check(d, e);
    check(br, er);
    @(posedge clock);
  endtask
  // one incoming message; verdict and forwarded copies compared
  task automatic sendIn(input logic p, input logic [7:0] st, d1, input logic acc, input logic [1:0] fwd);
    logic [1:0][7:0] g0;
    logic [7:0]      r2;
    g0 = got;
    r2 = 8'(rnd()) & 8'h7F;
    inValid <= p ? 2'h2 : 2'h1;
    inStatus <= {st, st};
    inData1 <= {d1, d1};
    inData2 <= {r2, r2};
    @(posedge clock);
    inValid <= 0;
    #1 check(acceptLocal[p], acc);
    repeat (4) @(posedge clock);
    for (int k = 0; k < 2; k++) begin
      check(got[k] - g0[k], fwd[k]);
      if (fwd[k]) begin
        check(lastStatus[k*8 +: 8], st);
        check({outData1[k*8 +: 8], outData2[k*8 +: 8]}, {d1, r2});
      end
    end
  endtask
  // one local message; whether it leaves, and its status byte
  task automatic sendLoc(input logic p, input logic [7:0] st, input logic nr, o, input logic [7:0] es);
    logic [1:0][7:0] g0;
    logic [7:0]      r1;
    logic [7:0]      r2;
    g0 = got;
    r1 = 8'(rnd()) & 8'h7F;
    r2 = 8'(rnd()) & 8'h7F;
    locValid <= 1;
    locPort <= p;
    locStatus <= st;
    locData1 <= r1;
    locData2 <= r2;
    locIsCtrl <= st[7:4] == 4'hB;
    locIsNrpn <= nr;
    waitHi(3);
    locValid <= 0;
    repeat (4) @(posedge clock);
    check(got[p] - g0[p], o);
    if (o) begin
      check(lastStatus[p*8 +: 8], es);
      check({outData1[p*8 +: 8], outData2[p*8 +: 8]}, {r1, r2});
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1;
    rd(`MPRF_REG_DINCFG, `MPRF_RST_PORTCFG, 2'h0);
    rd(`MPRF_REG_UNIT, 32'h0, 2'h0);
    rd(8'h18, 32'h0, 2'h2);
    wr(8'h18, 32'hFFFF_FFFF);
    // sysex taken only for the unit number, edges of the range first
    for (i = 0; i < 4; i++) begin
      u = i == 0 ? 4'h0 : i == 1 ? 4'hF : 4'(rnd());
      wr(`MPRF_REG_UNIT, {28'h0, u});
      sendIn(i[0], 8'hF0, {4'h0, u}, 1, 2'h0);
      sendIn(i[0], 8'hF0, {4'h0, u + 4'h1}, 0, 2'h0);
    end
    // a write with no byte lanes leaves the unit number alone
    s_axi_wstrb <= 4'h0;
    wr(`MPRF_REG_UNIT, {28'h0, ~u});
    s_axi_wstrb <= 4'hF;
    rd(`MPRF_REG_UNIT, {28'h0, u}, 2'h0);
    // single receive channel on din; system messages pass
    c = 4'(rnd());
    wr(`MPRF_REG_DINCFG, {20'h0, c, 8'h00});
    sendIn(0, {4'h9, c}, 8'h3C, 1, 2'h0);
    sendIn(0, {4'h9, c + 4'h1}, 8'h3C, 0, 2'h0);
    sendIn(0, 8'hF0, {4'h0, u}, 1, 2'h0);
    // controller modes and transmit channel; incoming cc always taken
    for (i = 0; i < 6; i++) begin
      t = 4'(rnd());
      n = 1'(rnd());
      wr(`MPRF_REG_DINCFG, {12'h0, t, 3'h0, i > 2, c, 6'h0, 2'(i % 3)});
      sendIn(0, {4'hB, c}, 8'h07, 1, 2'h0);
      sendLoc(0, 8'hB0, n, (i % 3 == 1 && !n) || (i % 3 == 2 && n), {4'hB, i > 2 ? c : t});
    end
    // program change direction both ways on usb
    for (i = 0; i < 4; i++) begin
      wr(`MPRF_REG_USBCFG, 32'h0000_0010 | (i << 2));
      sendIn(1, 8'hC0, 8'h05, i == 0 || i == 2, 2'h0);
      sendLoc(1, 8'hC3, 0, i == 1 || i == 2, 8'hC0);
    end
    // every pass-through combination, far side prompt and slow
    for (i = 0; i < 8; i++) begin
      wr(`MPRF_REG_THRU, i);
      slow <= i[0];
      sendIn(0, {4'h9, c}, 8'h3C, 1, {i[1], i[0]});
      sendIn(1, 8'h95, 8'h3C, 1, {1'b0, i[2]});
    end
    // chaining hides the din program setting and its thru
    wr(`MPRF_REG_DINCFG, {20'h0, c, 8'h0C});
    wr(`MPRF_REG_THRU, 32'h0000_0009);
    sendIn(0, {4'hC, c}, 8'h05, 1, 2'h0);
    wr(`MPRF_REG_THRU, 32'h0);
    sendIn(0, {4'hC, c}, 8'h05, 0, 2'h0);
    // every export type with random settings, one refused while busy, two bad types
    for (i = 0; i < 14; i++) begin
      d = rnd() & 32'h0007_F701 | 32'h8000_0000 | (i << 4);
      exportBusy <= i == 7;
      wr(`MPRF_REG_EXPORT, d);
      exportBusy <= 0;
      repeat (2) @(posedge clock);
      check(starts, i + (i < 7));
      if (i != 7) check(expo, expExport(d, `MPRF_DT_LAST));
    end
    // enable low freezes the readies
    enable <= 0;
    @(posedge clock);
    #1 check(locReady, 0);
    report_and_stop();
  end
endmodule
